// *** pkg/timer_and_ext_irq_control_pkg.sv ***
// constants for the timer and external interrupt control register block
`default_nettype none
package timer_and_ext_irq_control_pkg;
  localparam logic [7:0]  ctrl_offset    = 8'h88;
  // software-visible byte addresses on the axi4-lite slave
  localparam logic [11:0] addr_ctrl      = {4'h0, ctrl_offset};
  localparam logic [11:0] addr_irq_stat  = 12'h0100;
  localparam logic [11:0] addr_irq_mask  = 12'h0104;
  localparam logic [11:0] addr_service   = 12'h0108;
  // field positions within the control register
  localparam int bit_ext0_edge  = 0;
  localparam int bit_ext0_req   = 1;
  localparam int bit_ext1_edge  = 2;
  localparam int bit_ext1_req   = 3;
  localparam int bit_t0_run     = 4;
  localparam int bit_t0_ovf     = 5;
  localparam int bit_t1_run     = 6;
  localparam int bit_t1_ovf     = 7;
  localparam logic [7:0] ctrl_reset     = 8'h00;
  localparam logic [7:0] mask_reset     = 8'h00;
  localparam logic [1:0] resp_okay      = 2'b00;
  localparam logic [1:0] resp_slverr    = 2'b10;
endpackage : timer_and_ext_irq_control_pkg
`default_nettype wire

// *** rtl/timer_extint_control_reg.sv ***
// timer run control, external interrupt sensing and request flags behind axi4-lite
//
// The AXI4-Lite register port was chosen for this implementation.
`default_nettype none
// How it works
// - select bit 0 senses external interrupt by level, 1 by falling edge.
// - each external interrupt raises its own request flag on the selected condition.
// - servicing an external interrupt clears its request flag without software.
// - each timer run bit drives its count enable; zero holds the timer.
// - timer carry sets the overflow flag; servicing the timer interrupt clears it.
module timer_extint_control_reg
  import timer_and_ext_irq_control_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // external interrupt inputs, active low as on the classic port pins
  input  wire logic        ext_irq0_n,
  input  wire logic        ext_irq1_n,
  // timer carry pulses and service acknowledges from the interrupt controller
  input  wire logic        timer0_carry,
  input  wire logic        timer1_carry,
  input  wire logic [3:0]  service_ack,
  // outputs to the timers and interrupt controller
  output logic             timer0_run,
  output logic             timer1_run,
  output logic [3:0]       irq_request,
  output logic             irq
);

  logic [7:0] ctrl;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic       ext0_prev;
  logic       ext1_prev;
  logic       aw_held;
  logic       w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic       do_write;
  logic       wr_ctrl;
  logic       ext0_event;
  logic       ext1_event;
  logic [3:0] svc;
  logic [7:0] hw_set;
  logic       addr_ok;
  // control register fields, one flop each; ext0_rise and ext1_rise are combinational
  logic       ext_irq0_edge_select;
  logic       ext_irq1_edge_select;
  logic       ext_irq0_request;
  logic       ext_irq1_request;
  logic       timer0_overflow_flag;
  logic       timer1_overflow_flag;
  logic       ext0_rise;
  logic       ext1_rise;

  // write channel: address and data are caught separately, in either order
  // no new half is taken while a response is still pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl       = do_write && aw_addr == addr_ctrl && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // an unmapped write is answered with an error and changes nothing
  always_comb begin
    unique case (aw_addr)
      addr_ctrl, addr_irq_stat, addr_irq_mask, addr_service: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= resp_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // input sensing: the previous sample gives a one-to-zero edge
  // it resets high, the pins' idle level, so no false edge follows reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext0_prev <= 1'b1;
      ext1_prev <= 1'b1;
    end else begin
      ext0_prev <= ext_irq0_n;
      ext1_prev <= ext_irq1_n;
    end
  end

  // level mode follows the pin while low; edge mode latches a falling edge
  assign ext0_event = ctrl[bit_ext0_edge] ? (ext0_prev && !ext_irq0_n)
                                          : !ext_irq0_n;
  assign ext1_event = ctrl[bit_ext1_edge] ? (ext1_prev && !ext_irq1_n)
                                          : !ext_irq1_n;

  // service acknowledges: [0] ext0, [1] timer0, [2] ext1, [3] timer1;
  // software may also pulse them through the service register
  assign svc = service_ack
             | ((do_write && aw_addr == addr_service && w_strb[0]) ? w_data[3:0] : 4'h0);

  // software-owned bits: edge selects and run controls follow every control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_irq0_edge_select <= ctrl_reset[bit_ext0_edge];
      ext_irq1_edge_select <= ctrl_reset[bit_ext1_edge];
      timer0_run           <= ctrl_reset[bit_t0_run];
      timer1_run           <= ctrl_reset[bit_t1_run];
    end else if (wr_ctrl) begin
      ext_irq0_edge_select <= w_data[bit_ext0_edge];
      ext_irq1_edge_select <= w_data[bit_ext1_edge];
      timer0_run           <= w_data[bit_t0_run];
      timer1_run           <= w_data[bit_t1_run];
    end
  end

  // request flags: a new event beats a service clear, which beats a software write,
  // so no request is lost when they meet in one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_irq0_request <= ctrl_reset[bit_ext0_req];
    end else if (ext0_event) begin
      ext_irq0_request <= 1'b1;
    end else if (svc[0]) begin
      ext_irq0_request <= 1'b0;
    end else if (wr_ctrl && ext_irq0_edge_select) begin
      ext_irq0_request <= w_data[bit_ext0_req];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_irq1_request <= ctrl_reset[bit_ext1_req];
    end else if (ext1_event) begin
      ext_irq1_request <= 1'b1;
    end else if (svc[2]) begin
      ext_irq1_request <= 1'b0;
    end else if (wr_ctrl && ext_irq1_edge_select) begin
      ext_irq1_request <= w_data[bit_ext1_req];
    end
  end

  // overflow flags are hardware owned: a control write leaves them alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer0_overflow_flag <= ctrl_reset[bit_t0_ovf];
    end else if (timer0_carry) begin
      timer0_overflow_flag <= 1'b1;
    end else if (svc[1]) begin
      timer0_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer1_overflow_flag <= ctrl_reset[bit_t1_ovf];
    end else if (timer1_carry) begin
      timer1_overflow_flag <= 1'b1;
    end else if (svc[3]) begin
      timer1_overflow_flag <= 1'b0;
    end
  end

  // the register as software sees it
  always_comb begin
    ctrl                = 8'h00;
    ctrl[bit_ext0_edge] = ext_irq0_edge_select;
    ctrl[bit_ext0_req]  = ext_irq0_request;
    ctrl[bit_ext1_edge] = ext_irq1_edge_select;
    ctrl[bit_ext1_req]  = ext_irq1_request;
    ctrl[bit_t0_run]    = timer0_run;
    ctrl[bit_t0_ovf]    = timer0_overflow_flag;
    ctrl[bit_t1_run]    = timer1_run;
    ctrl[bit_t1_ovf]    = timer1_overflow_flag;
  end

  // a request rises on an event or, in edge mode, on a software set that no service clear cancels;
  // a software set acts as a detected request, so it reaches the status as well
  assign ext0_rise = !ext_irq0_request
                   && (ext0_event || (wr_ctrl && ext_irq0_edge_select
                       && w_data[bit_ext0_req] && !svc[0]));
  assign ext1_rise = !ext_irq1_request
                   && (ext1_event || (wr_ctrl && ext_irq1_edge_select
                       && w_data[bit_ext1_req] && !svc[2]));

  // sticky status: each flag assertion also sets its status bit
  always_comb begin
    hw_set               = 8'h00;
    hw_set[bit_ext0_req] = ext0_rise;
    hw_set[bit_ext1_req] = ext1_rise;
    hw_set[bit_t0_ovf]   = timer0_carry;
    hw_set[bit_t1_ovf]   = timer1_carry;
  end

  // a written one clears a status bit, but a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 8'h00;
    end else if (do_write && aw_addr == addr_irq_stat && w_strb[0]) begin
      irq_stat <= (irq_stat & ~w_data[7:0]) | hw_set;
    end else begin
      irq_stat <= irq_stat | hw_set;
    end
  end

  // the mask gates only irq; flags and status still record every event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= mask_reset;
    end else if (do_write && aw_addr == addr_irq_mask && w_strb[0]) begin
      irq_mask <= w_data[7:0];
    end
  end

  // level interrupt: high while any unmasked status bit is set
  assign irq         = |(irq_stat & irq_mask);
  // order matches service_ack, so each acknowledge clears the flag it names
  assign irq_request = {ctrl[bit_t1_ovf], ctrl[bit_ext1_req],
                        ctrl[bit_t0_ovf], ctrl[bit_ext0_req]};

  // read channel: one cycle after the address is taken
  // reads have no side effect: flags clear only by service or by a write
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= resp_okay;
      unique case (s_axi_araddr)
        addr_ctrl:     s_axi_rdata <= {24'h00_0000, ctrl};
        addr_irq_stat: s_axi_rdata <= {24'h00_0000, irq_stat};
        addr_irq_mask: s_axi_rdata <= {24'h00_0000, irq_mask};
        addr_service:  s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= resp_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : timer_extint_control_reg
`default_nettype wire

// *** bench/timer_extint_control_reg_assertions.sv ***
// assertions watching the control register block at its ports
`default_nettype none
module timer_extint_control_reg_assertions (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       ext_irq0_n,
  input wire logic       timer0_carry,
  input wire logic [3:0] service_ack,
  input wire logic       timer0_run,
  input wire logic [3:0] irq_request,
  input wire logic       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_run; !$stable(timer0_run) |-> $rose(s_axi_bvalid); endproperty
  a_run: assert property (p_run) else $error("run bit moved without a write");
  // a request rises only from a pin sampled low one edge before, or from a control write
  property p_req; $rose(irq_request[0]) |-> $rose(s_axi_bvalid) || !$past(ext_irq0_n);
  endproperty
  a_req: assert property (p_req) else $error("request rose with no cause");
  property p_eclr; ext_irq0_n[*5] ##0 (service_ack[0] && s_axi_awready) |=> !irq_request[0];
  endproperty
  a_eclr: assert property (p_eclr) else $error("request survived service");
  property p_ovf; timer0_carry |=> irq_request[1]; endproperty
  a_ovf: assert property (p_ovf) else $error("carry not flagged");
  property p_oclr; service_ack[1] && !timer0_carry |=> !irq_request[1]; endproperty
  a_oclr: assert property (p_oclr) else $error("overflow survived service");
  property p_oset; $rose(irq_request[1]) |-> $past(timer0_carry); endproperty
  a_oset: assert property (p_oset) else $error("overflow rose without carry");
  property p_irq; $fell(irq) |-> $rose(s_axi_bvalid); endproperty
  a_irq: assert property (p_irq) else $error("irq fell without a write");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  c_ovf: cover property (timer0_carry);
  c_req: cover property ($rose(irq_request[0]));
  c_irq: cover property ($fell(irq));
endmodule : timer_extint_control_reg_assertions
bind timer_extint_control_reg timer_extint_control_reg_assertions
  timer_extint_control_reg_assertions_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ext_irq0_n, .timer0_carry, .service_ack,
  .timer0_run, .irq_request, .irq);
`default_nettype wire

// *** bench/timer_extint_control_reg_tb_top.sv ***
// self-checking bench for the timer and external interrupt control register block
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module timer_extint_control_reg_tb_top import timer_and_ext_irq_control_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, timer0_run, timer1_run, irq;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pins = 2'b11, carry = 2'b00;
  logic [3:0]  service_ack = '0, irq_request;
  logic [33:0] exp_q[$];
  logic [1:0]  exp_b[$];
  int          n_fail = 0, samples_checked = 0;
  timer_extint_control_reg timer_extint_control_reg_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .ext_irq0_n(pins[0]), .ext_irq1_n(pins[1]), .timer0_carry(carry[0]),
    .timer1_carry(carry[1]), .service_ack, .timer0_run, .timer1_run, .irq_request, .irq);
  initial forever #2 aclk = ~aclk;
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // 0 arready, 1 rvalid, otherwise bvalid
  function automatic logic sig_hi(input int w);
    case (w)
      0:       return s_axi_arready;
      1:       return s_axi_rvalid;
      default: return s_axi_bvalid;
    endcase
  endfunction : sig_hi
  task automatic wait_hi(input int w);
    int i;
    i = 0;
    do begin
      @(negedge aclk);
      i++;
    end while (sig_hi(w) !== 1'b1 && i < 50);
    if (sig_hi(w) !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    @(posedge aclk);
  endtask : wait_hi
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = resp_okay);
    logic ra, rw;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int i = 0; i < 50 && (i == 0 || s_axi_awvalid || s_axi_wvalid); i++) begin
      @(negedge aclk);
      ra = s_axi_awready;
      rw = s_axi_wready;
      @(posedge aclk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
    end
    wait_hi(2);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = resp_okay);
    exp_q.push_back({r, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wait_hi(0);
    s_axi_arvalid <= 1'b0;
    wait_hi(1);
  endtask : rd
  // c selects a timer carry (1) or a service acknowledge (0)
  task automatic pulse(input int c, input int b);
    if (c) carry[b] <= 1'b1;
    else service_ack[b] <= 1'b1;
    @(posedge aclk);
    carry <= '0;
    service_ack <= '0;
    repeat (2) @(posedge aclk);
  endtask : pulse
  always @(posedge aclk) begin
    logic [33:0] e;
    logic [1:0]  b;
    if (s_axi_rvalid === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK("read", e, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid === 1'b1 && exp_b.size() > 0) begin
      b = exp_b.pop_front();
      `CHK("bresp", b, s_axi_bresp)
    end
  end
  initial begin
    logic [31:0] d;
    void'($urandom(45));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(addr_ctrl, 32'(ctrl_reset));
    rd(addr_irq_mask, 32'(mask_reset));
    wr(12'h0ffc, '1, resp_slverr);
    rd(12'h0ffc, '0, resp_slverr);
    for (int i = 0; i < 4; i++) begin
      d = $urandom & 32'h0000_0050;
      wr(addr_ctrl, d);
      `CHK("run0", d[bit_t0_run], timer0_run)
      `CHK("run1", d[bit_t1_run], timer1_run)
    end
    $display("reset, map and run test done");
    wr(addr_irq_mask, 32'h0000_00aa);
    for (int k = 0; k < 2; k++) begin
      wr(addr_ctrl, '0);
      pins[k] <= 1'b0;
      repeat (3) @(posedge aclk);
      rd(addr_ctrl, 2 << 2 * k);
      pins[k] <= 1'b1;
      repeat (4) @(posedge aclk);
      pulse(0, 2 * k);
      rd(addr_ctrl, 0);
      wr(addr_ctrl, 2 << 2 * k);
      rd(addr_ctrl, 0);
      wr(addr_ctrl, 1 << 2 * k);
      pins[k] <= 1'b0;
      repeat (3) @(posedge aclk);
      pulse(0, 2 * k);
      // a pin left low gives no fresh edge, so the request stays clear
      rd(addr_ctrl, 1 << 2 * k);
      wr(addr_ctrl, 3 << 2 * k);
      pins[k] <= 1'b1;
      pulse(1, k);
      rd(addr_ctrl, 3 << 2 * k | 1 << 5 + 2 * k);
      pulse(0, 1 + 2 * k);
      wr(addr_ctrl, 1 << 2 * k);
      rd(addr_ctrl, 1 << 2 * k);
    end
    $display("flag test done");
    `CHK("irq", 1'b1, irq)
    wr(addr_irq_stat, 32'h0000_00ff);
    `CHK("irq", 1'b0, irq)
    wr(addr_irq_mask, '0);
    pulse(1, 0);
    `CHK("irq", 1'b0, irq)
    rd(addr_irq_stat, 32'h0000_0020);
    // a software set in edge mode must reach the status like a detected request
    wr(addr_ctrl, 32'h0000_0001);
    wr(addr_ctrl, 32'h0000_0003);
    rd(addr_irq_stat, 32'h0000_0022);
    $display("irq test done");
    print_verdict();
  end
endmodule : timer_extint_control_reg_tb_top
`default_nettype wire
